// ==== hw/sdram_cmd_defines.vh ====
// Notes on behaviour
// - each command is decoded against the state of the bank picked by bank_select.
// - idle bank treats deselect and all-high as nop; gate drop means power-down.
// - activate to idle bank opens it and latches the row address.
// - read to an open row starts a burst, latches column and auto-precharge bit.
// - write to an open row starts a burst, latches column and auto-precharge bit.
// - nop or deselect lets a plain burst finish, then the bank is row-active.
// - burst stop ends the burst at once, bank stays row-active.
// - new read or write cuts a plain burst and starts afresh with new bit.
// - precharge during a plain burst ends it and closes the bank.
// - auto-precharge burst runs out then precharges itself; no bank commands meanwhile.
// - precharging bank goes idle after precharge time; precharge to idle is nop.
// - activating bank becomes row-active after activate-to-column delay; only nop meanwhile.
// - refresh returns to idle after row cycle time; only nop during refresh or mode load.
// - power-down held while gate low; gate rise with nop exits to idle.
// - self-refresh held while gate low; exit with nop, idle after row cycle time.
// - gate rise re-enables inputs; controller waits setup before non-exit commands.
// - gate high in both cycles means normal per-bank decoding.
// - self-refresh exit starts on second edge after gate rise, lasts row cycle time.
`ifndef SDRAM_CMD_DEFINES_VH
`define SDRAM_CMD_DEFINES_VH
`define CLK_PERIOD_PS        10000
`define PRECHARGE_TIME_PS    20000
`define ACT_TO_COL_PS        20000
`define ROW_CYCLE_PS         67500
`define WRITE_RECOVERY_PS    15000
// least times, rounded up to whole cycles
`define PRECHARGE_CYC  ((`PRECHARGE_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ACT_TO_COL_CYC ((`ACT_TO_COL_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ROW_CYCLE_CYC  ((`ROW_CYCLE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_REC_CYC  ((`WRITE_RECOVERY_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MODE_LOAD_CYC  2
`define SREX_EDGE      2
`define BURST_LEN      4
// bank states
`define BK_IDLE   3'h0
`define BK_ACTING 3'h1
`define BK_ACTIVE 3'h2
`define BK_READ   3'h3
`define BK_WRITE  3'h4
`define BK_PRECH  3'h5
`define BK_WREC   3'h6
// chip states
`define CH_NORMAL 3'h0
`define CH_REFR   3'h1
`define CH_MODE   3'h2
`define CH_PDOWN  3'h3
`define CH_SELF   3'h4
`define CH_SREX   3'h5
`define AP_BIT    10
`endif

// ==== hw/sdram_command_state_logic.v ====
`timescale 1ns/1ps
`include "sdram_cmd_defines.vh"
module sdram_command_state_logic (
    input  wire        clk,            // system clock, 100 MHz
    input  wire        resetn,         // synchronous reset, active low
    // gate, command and address inputs, all taken on the rising edge
    input  wire        clk_gate,       // clock enable from controller
    input  wire        chip_sel_n,     // chip select, active low
    input  wire        row_strobe_n,   // row strobe, active low
    input  wire        col_strobe_n,   // column strobe, active low
    input  wire        write_en_n,     // write enable, active low
    input  wire [1:0]  bank_select,    // bank address
    input  wire [12:0] addr,           // row / column address
    // status outputs, every one straight from a flop
    output reg  [11:0] bank_state,     // 3 bits per bank, bank 0 low
    output reg  [2:0]  chip_state,     // chip-wide state
    output reg  [12:0] row_addr,       // last latched row address
    output reg  [8:0]  column_addr,    // last latched column address
    output reg         auto_precharge_bit, // auto-precharge of last legal column command
    output reg         illegal_cmd     // one-cycle pulse on illegal command
);
    // limitations a user must know:
    // - burst length is fixed at four; no mode field changes it
    // - precharge of all banks through the address bit is not modelled,
    //   a precharge only ever closes the bank picked by bank_select
    // - timers count whole cycles of the one clock, rounded up, so a
    //   faster clock needs the cycle figures in the header redone
    // - an illegal command is flagged and otherwise ignored, except on
    //   leaving power-down or self-refresh, where the exit still happens
    // - data, masks and the power-up sequence are outside this block
    // - the gate history is kept in every chip state, so exit edges are
    //   seen even while the chip sits in low power

    // timer loads in cycles; counts are small, so eight bits are kept on purpose
    localparam integer PRE_I = `PRECHARGE_CYC;
    localparam integer ACT_I = `ACT_TO_COL_CYC;
    localparam integer RC_I  = `ROW_CYCLE_CYC;
    localparam integer WR_I  = `WRITE_REC_CYC;
    localparam integer MR_I  = `MODE_LOAD_CYC;
    localparam integer BL_I  = `BURST_LEN;

    localparam [7:0] PRE_C = PRE_I[7:0];
    localparam [7:0] ACT_C = ACT_I[7:0];
    localparam [7:0] RC_C  = RC_I[7:0];
    localparam [7:0] WR_C  = WR_I[7:0];
    localparam [7:0] MR_C  = MR_I[7:0];
    localparam [7:0] BL_C  = BL_I[7:0];

    // registered state
    reg        gate_prev_q;
    reg [2:0]  bst_q [0:3];
    reg [7:0]  bcnt_q [0:3];
    reg [3:0]  bap_q;
    reg [7:0]  ccnt_q;
    reg [1:0]  srex_q;

    // next-state values built by the decode
    reg [2:0]  st_n [0:3];
    reg [7:0]  cnt_n [0:3];
    reg [3:0]  ap_n;
    reg [2:0]  cst_d;
    reg [7:0]  ccnt_d;
    reg [1:0]  srex_d;
    reg        ill_d;

    // scratch for the decode: idle summary, addressed state, loop index
    reg        all_idle;
    reg [2:0]  cur;
    integer    i;

    // command decode, 4-bit code {cs,ras,cas,we}
    wire [3:0] cmd     = {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n};
    wire       is_nop  = chip_sel_n | (cmd[2:0] == 3'b111);
    wire       is_act  = (cmd == 4'b0011);
    wire       is_rd   = (cmd == 4'b0101);
    wire       is_wr   = (cmd == 4'b0100);
    wire       is_bst  = (cmd == 4'b0110);
    wire       is_pre  = (cmd == 4'b0010);
    wire       is_ref  = (cmd == 4'b0001);
    wire       is_mrs  = (cmd == 4'b0000);
    // address bit that picks auto-precharge on column commands
    wire       ap_in   = addr[`AP_BIT];
    // gate high now and at the previous edge; only then is a command decoded against a bank
    wire       gate_hh = gate_prev_q & clk_gate;

    // state that a bank enters when a timer expires
    function [2:0] after_timer;
        input [2:0] s;
        input       ap;
        begin
            case (s)
                `BK_ACTING: after_timer = `BK_ACTIVE;
                `BK_READ:   after_timer = ap ? `BK_PRECH : `BK_ACTIVE;
                `BK_WRITE:  after_timer = ap ? `BK_WREC : `BK_ACTIVE;
                // write with auto-precharge waits out write recovery first,
                // so the array is never closed on data still being written
                `BK_WREC:   after_timer = `BK_PRECH;
                `BK_PRECH:  after_timer = `BK_IDLE;
                default:    after_timer = s;
            endcase
        end
    endfunction

    // timer load for a state just entered
    function [7:0] load_for;
        input [2:0] s;
        begin
            case (s)
                `BK_ACTING: load_for = ACT_C;
                `BK_READ:   load_for = BL_C;
                `BK_WRITE:  load_for = BL_C;
                `BK_WREC:   load_for = WR_C;
                `BK_PRECH:  load_for = PRE_C;
                // states without a timer load zero so the counter rests
                default:    load_for = 8'h00;
            endcase
        end
    endfunction

    // next state: timers first, then the command to the addressed bank
    always @* begin
        ill_d    = 1'b0;
        cst_d    = chip_state;
        ccnt_d   = (ccnt_q != 8'h00) ? ccnt_q - 8'h01 : 8'h00;
        srex_d   = srex_q;
        all_idle = 1'b1;
        cur      = 3'h0;
        // every bank's timer runs, whichever bank is addressed
        for (i = 0; i < 4; i = i + 1) begin
            st_n[i]  = bst_q[i];
            cnt_n[i] = bcnt_q[i];
            ap_n[i]  = bap_q[i];
            // refresh, mode load and low-power entry need all four banks idle
            if (bst_q[i] != `BK_IDLE)
                all_idle = 1'b0;
            if (bcnt_q[i] > 8'h01) begin
                cnt_n[i] = bcnt_q[i] - 8'h01;
            end else if (bcnt_q[i] == 8'h01) begin
                st_n[i]  = after_timer(bst_q[i], bap_q[i]);
                cnt_n[i] = load_for(st_n[i]);
            end
        end
        case (chip_state)
            `CH_NORMAL: begin
                if (gate_prev_q & ~clk_gate) begin
                    // entry only legal with all banks idle
                    if (is_nop & all_idle)
                        cst_d = `CH_PDOWN;
                    else if (is_ref & all_idle)
                        cst_d = `CH_SELF;
                    else
                        ill_d = 1'b1;
                end else if (gate_hh & ~is_nop) begin
                    // decode against the addressed bank only
                    cur = bst_q[bank_select];
                    case (cur)
                        `BK_IDLE: begin
                            if (is_act) begin
                                st_n[bank_select]  = `BK_ACTING;
                                cnt_n[bank_select] = ACT_C;
                            end else if (is_pre) begin
                                // nop to an idle bank
                            end else if ((is_ref | is_mrs) & all_idle) begin
                                cst_d  = is_ref ? `CH_REFR : `CH_MODE;
                                ccnt_d = is_ref ? RC_C : MR_C;
                            end else
                                ill_d = 1'b1;
                        end
                        `BK_ACTIVE, `BK_READ, `BK_WRITE: begin
                            if (is_rd | is_wr) begin
                                // cuts any plain burst; ap taken afresh
                                st_n[bank_select]  = is_rd ? `BK_READ : `BK_WRITE;
                                cnt_n[bank_select] = BL_C;
                                ap_n[bank_select]  = ap_in;
                            end else if (is_pre) begin
                                st_n[bank_select]  = `BK_PRECH;
                                cnt_n[bank_select] = PRE_C;
                            end else if (is_bst & (cur != `BK_ACTIVE)) begin
                                st_n[bank_select]  = `BK_ACTIVE;
                                cnt_n[bank_select] = 8'h00;
                            end else
                                // activate, refresh, mode load, stop to a resting row
                                ill_d = 1'b1;
                        end
                        // only a repeat precharge is tolerated while precharging
                        `BK_PRECH: begin
                            if (!is_pre)
                                ill_d = 1'b1;
                        end
                        // activating and write-recovering banks take nop only
                        default:
                            ill_d = 1'b1;
                    endcase
                    // auto-precharge bursts accept no command at all; the running
                    // timer carries on as if the command had been a nop
                    if ((cur == `BK_READ || cur == `BK_WRITE) && bap_q[bank_select]) begin
                        if (bcnt_q[bank_select] == 8'h01) begin
                            st_n[bank_select]  = after_timer(bst_q[bank_select], 1'b1);
                            cnt_n[bank_select] = load_for(st_n[bank_select]);
                        end else begin
                            st_n[bank_select]  = bst_q[bank_select];
                            cnt_n[bank_select] = bcnt_q[bank_select] - 8'h01;
                        end
                        ap_n[bank_select]  = 1'b1;
                        ill_d              = 1'b1;
                    end
                end
            end

            // the chip-wide counter was loaded when the command was taken
            `CH_REFR, `CH_MODE: begin
                if (gate_hh & ~is_nop)
                    ill_d = 1'b1;
                if (ccnt_q <= 8'h01)
                    cst_d = `CH_NORMAL;
            end

            // any gate rise leaves power-down; a non-nop is flagged, not obeyed
            `CH_PDOWN: begin
                if (clk_gate) begin
                    cst_d = `CH_NORMAL;
                    ill_d = ~is_nop;
                end
            end

            // gate rise starts the exit; the refresh keeps going until then
            `CH_SELF: begin
                if (clk_gate) begin
                    cst_d  = `CH_SREX;
                    srex_d = 2'h1;
                    ill_d  = ~is_nop;
                end
            end

            // commands during the exit are flagged, the exit is not held up
            `CH_SREX: begin
                // exit counted from the second edge after the gate rise
                if (srex_q < `SREX_EDGE) begin
                    srex_d = srex_q + 2'h1;
                    ccnt_d = RC_C;
                end else if (ccnt_q <= 8'h01)
                    cst_d = `CH_NORMAL;
                if (gate_hh & ~is_nop)
                    ill_d = 1'b1;
            end

            default:
                cst_d = `CH_NORMAL;
        endcase
    end

    // state registers; outputs straight from flops
    always @(posedge clk) begin
        // gate history cleared too, so the first edge after reset decodes nothing
        if (!resetn) begin
            gate_prev_q        <= 1'b0;
            chip_state         <= `CH_NORMAL;
            ccnt_q             <= 8'h00;
            srex_q             <= 2'h0;
            bap_q              <= 4'h0;
            illegal_cmd        <= 1'b0;
            row_addr           <= 13'h0000;
            column_addr        <= 9'h000;
            auto_precharge_bit <= 1'b0;
            bank_state         <= 12'h000;
            for (i = 0; i < 4; i = i + 1) begin
                bst_q[i]  <= `BK_IDLE;
                bcnt_q[i] <= 8'h00;
            end
        end else begin
            // counters and states advance every cycle, gate or not
            gate_prev_q <= clk_gate;
            chip_state  <= cst_d;
            ccnt_q      <= ccnt_d;
            srex_q      <= srex_d;
            bap_q       <= ap_n;
            illegal_cmd <= ill_d;
            for (i = 0; i < 4; i = i + 1) begin
                bst_q[i]  <= st_n[i];
                bcnt_q[i] <= cnt_n[i];
            end
            // the output copies the next states, so it is never a cycle behind
            bank_state <= {st_n[3], st_n[2], st_n[1], st_n[0]};
            // latch addresses only when a command is actually taken
            if (chip_state == `CH_NORMAL && gate_hh && !ill_d) begin
                if (is_act)
                    row_addr <= addr;
                // column and its auto-precharge bit from the last legal column command
                if (is_rd | is_wr) begin
                    column_addr        <= addr[8:0];
                    auto_precharge_bit <= ap_in;
                end
            end
        end
    end
endmodule // sdram_command_state_logic

// ==== tb/sdram_command_state_logic_properties.sv ====
`timescale 1ns/1ps
`include "sdram_cmd_defines.vh"
module sdram_command_state_logic_properties (
    input wire        clk,                // clock
    input wire        resetn,             // reset
    input wire        clk_gate,           // gate
    input wire        chip_sel_n,         // select
    input wire        row_strobe_n,       // row
    input wire        col_strobe_n,       // column
    input wire        write_en_n,         // write
    input wire [1:0]  bank_select,        // bank
    input wire [12:0] addr,               // address
    input wire [11:0] bank_state,         // banks
    input wire [2:0]  chip_state,         // chip
    input wire [12:0] row_addr,           // row
    input wire [8:0]  column_addr,        // column
    input wire        auto_precharge_bit, // ap
    input wire        illegal_cmd         // flag
);
    reg        gp_q;
    reg        ap0_q;
    wire [3:0] cmd = {chip_sel_n, row_strobe_n, col_strobe_n, write_en_n};
    wire [2:0] bs0 = bank_state[2:0];
    wire       b0  = clk_gate && gp_q && chip_state == `CH_NORMAL && bank_select == 2'h0;
    wire       bu0 = (bs0 == `BK_READ || bs0 == `BK_WRITE) && !ap0_q; // plain burst
    // own copy of the gate history and of bank 0's auto-precharge choice
    always @(posedge clk) begin
        if (!resetn) begin
            gp_q  <= 1'b0;
            ap0_q <= 1'b0;
        end else begin
            gp_q <= clk_gate;
            if (b0 && cmd[3:1] == 3'h2 && (bs0 == `BK_ACTIVE || bu0)) ap0_q <= addr[`AP_BIT];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_act_opens_bank: assert property (
        b0 && cmd == 4'h3 && bs0 == `BK_IDLE |=> bs0 == `BK_ACTING && row_addr == $past(addr))
        else $error("activate failed");
    a_acting_delay: assert property (
        bs0 == `BK_ACTING && $past(bs0) != `BK_ACTING |-> ##2 bs0 == `BK_ACTIVE)
        else $error("activate delay wrong");
    a_read_start: assert property (
        b0 && cmd == 4'h5 && (bs0 == `BK_ACTIVE || bu0) |=> bs0 == `BK_READ
        && column_addr == $past(addr[8:0]) && auto_precharge_bit == $past(addr[10])) else $error("read failed");
    a_write_start: assert property (
        b0 && cmd == 4'h4 && (bs0 == `BK_ACTIVE || bu0) |=> bs0 == `BK_WRITE
        && column_addr == $past(addr[8:0])) else $error("write failed");
    a_stop_burst: assert property (
        b0 && cmd == 4'h6 && bu0 |=> bs0 == `BK_ACTIVE) else $error("stop failed");
    a_prech_time: assert property (
        bs0 == `BK_PRECH && $past(bs0) != `BK_PRECH |-> ##2 bs0 == `BK_IDLE) else $error("precharge time wrong");
    a_illegal_act: assert property (
        b0 && cmd == 4'h3 && bs0 == `BK_ACTIVE |=> illegal_cmd && bs0 == `BK_ACTIVE) else $error("no illegal flag");
    a_refresh_time: assert property (
        clk_gate && gp_q && chip_state == `CH_NORMAL && cmd == 4'h1 && bank_state == 12'h000
        |=> chip_state == `CH_REFR [*7] ##1 chip_state == `CH_NORMAL) else $error("refresh time wrong");
endmodule // sdram_command_state_logic_properties

// ==== tb/sdram_ctrl_model.sv ====
`timescale 1ns/1ps
module sdram_ctrl_model (
    input  wire        clk,                 // clock
    input  wire [3:0]  req_cmd,             // strobes wanted
    input  wire [1:0]  req_bank,            // bank wanted
    input  wire [12:0] req_addr,            // address wanted
    input  wire        req_gate,            // gate wanted
    output reg         clk_gate     = 1'b1, // gate
    output reg         chip_sel_n   = 1'b1, // select
    output reg         row_strobe_n = 1'b1, // row
    output reg         col_strobe_n = 1'b1, // column
    output reg         write_en_n   = 1'b1, // write
    output reg  [1:0]  bank_select  = 2'h0, // bank
    output reg  [12:0] addr         = 13'h0000 // address
);
    // launch on the falling edge; deselect churns strobes, bank and address, nop the address, so stale values never help
    // requests come already ordered and spaced by the bench
    always @(negedge clk) begin
        clk_gate <= req_gate;
        chip_sel_n <= req_cmd[3];
        {row_strobe_n, col_strobe_n, write_en_n} <= req_cmd[3] ? ~{row_strobe_n, col_strobe_n, write_en_n} : req_cmd[2:0];
        bank_select <= req_cmd[3] ? ~bank_select : req_bank;
        addr <= (req_cmd[3] || req_cmd[2:0] == 3'h7) ? ~addr : req_addr;
    end
endmodule // sdram_ctrl_model

// ==== tb/test_sdram_command_state_logic.sv ====
`timescale 1ns/1ps
`include "sdram_cmd_defines.vh"
module test_sdram_command_state_logic;
    localparam [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4, BST = 4'h6, PRE = 4'h2, REF = 4'h1, MRS = 4'h0;
    reg         clk = 1'b0;
    reg         resetn = 1'b0;
    reg  [3:0]  rc = 4'h7;
    reg  [1:0]  rb = 2'h0;
    reg  [12:0] ra = 13'h0000;
    reg         rg = 1'b1;
    reg  [31:0] r;
    reg  [3:0]  c;
    wire        clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, auto_precharge_bit, illegal_cmd;
    wire [1:0]  bank_select;
    wire [12:0] addr, row_addr;
    wire [11:0] bank_state;
    wire [2:0]  chip_state;
    wire [8:0]  column_addr;
    integer     n_mismatch = 0, checks_done = 0, cycles = 0, i;
    always #5 clk = ~clk;
    sdram_ctrl_model sdram_ctrl_model_inst (.clk(clk), .req_cmd(rc), .req_bank(rb), .req_addr(ra), .req_gate(rg),
        .clk_gate(clk_gate), .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_en_n(write_en_n), .bank_select(bank_select), .addr(addr));
    sdram_command_state_logic sdram_command_state_logic_inst (.clk(clk), .resetn(resetn), .clk_gate(clk_gate),
        .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
        .bank_select(bank_select), .addr(addr), .bank_state(bank_state), .chip_state(chip_state), .row_addr(row_addr),
        .column_addr(column_addr), .auto_precharge_bit(auto_precharge_bit), .illegal_cmd(illegal_cmd));
    task complete_run;
        begin
            $display("mismatches %0d checks %0d", n_mismatch, checks_done);
            if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [8*8-1:0] what, input [15:0] exp, input [15:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // one command a cycle; returns once its result has landed
    task go(input [3:0] cc, input [1:0] b, input [12:0] ad, input g);
        begin
            rc = cc;
            rb = b;
            ra = ad;
            rg = g;
            @(posedge clk);
            #2;
        end
    endtask
    task idle(input integer n, input g);
        repeat (n) go(NOP, 2'h0, 13'h0000, g);
    endtask
    function [2:0] st(input [1:0] b);
        st = bank_state[3*b +: 3];
    endfunction
    function [2:0] col_state(input [3:0] cc);
        col_state = (cc == WR) ? `BK_WRITE : `BK_READ;
    endfunction
    // hang guard, far above the roughly eighty cycles the run needs
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end
    initial begin
        r = $urandom(32'haf58_47d4);
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        idle(1, 1'b1);
        // open all banks back to back at random rows
        for (i = 0; i < 4; i = i + 1) begin
            r = $urandom;
            go(ACT, i[1:0], r[12:0], 1'b1);
            chk("row", r[12:0], row_addr);
            chk("acting", `BK_ACTING, st(i[1:0]));
        end
        idle(2, 1'b1);
        chk("active", {4{`BK_ACTIVE}}, bank_state);
        // chained column commands on bank 0 cut each other
        for (i = 0; i < 3; i = i + 1) begin
            r = $urandom;
            r[10] = 1'b0;
            c = (i == 1) ? WR : RD;
            go(c, 2'h0, r[12:0], 1'b1);
            chk("burst", col_state(c), st(2'h0));
            chk("column", r[8:0], column_addr);
            chk("ap", 1'b0, auto_precharge_bit);
        end
        go(BST, 2'h0, 13'h0000, 1'b1);
        chk("stop", `BK_ACTIVE, st(2'h0));
        go(ACT, 2'h0, 13'h0000, 1'b1);
        chk("illegal", 1'b1, illegal_cmd);
        chk("kept", `BK_ACTIVE, st(2'h0));
        go(RD, 2'h1, 13'h0005, 1'b1);
        chk("pulse", 1'b0, illegal_cmd);
        idle(4, 1'b1);
        chk("end", `BK_ACTIVE, st(2'h1));
        go(WR, 2'h1, 13'h0009, 1'b1);
        go(PRE, 2'h1, 13'h0000, 1'b1);
        chk("prech", `BK_PRECH, st(2'h1));
        idle(2, 1'b1);
        chk("closed", `BK_IDLE, st(2'h1));
        go(PRE, 2'h1, 13'h0000, 1'b1);
        chk("pre nop", {1'b0, `BK_IDLE}, {illegal_cmd, st(2'h1)});
        // auto-precharge read on bank 2, poked while it runs
        go(RD, 2'h2, 13'h0403, 1'b1);
        chk("ap", 1'b1, auto_precharge_bit);
        go(RD, 2'h2, 13'h0000, 1'b1);
        chk("ap busy", 1'b1, illegal_cmd);
        idle(3, 1'b1);
        chk("self pre", `BK_PRECH, st(2'h2));
        go(REF, 2'h0, 13'h0000, 1'b1);
        chk("ref busy", 1'b1, illegal_cmd);
        go(PRE, 2'h0, 13'h0000, 1'b1);
        go(PRE, 2'h3, 13'h0000, 1'b1);
        idle(2, 1'b1);
        chk("all idle", 12'h000, bank_state);
        go(REF, 2'h0, 13'h0000, 1'b1);
        idle(6, 1'b1);
        chk("refresh", `CH_REFR, chip_state);
        idle(1, 1'b1);
        chk("ref done", `CH_NORMAL, chip_state);
        go(MRS, 2'h0, 13'h0000, 1'b1);
        chk("mode", `CH_MODE, chip_state);
        idle(2, 1'b1);
        chk("mode end", `CH_NORMAL, chip_state);
        // power-down then self-refresh under the clock gate
        idle(4, 1'b0);
        chk("pdown", `CH_PDOWN, chip_state);
        idle(1, 1'b1);
        chk("pd exit", `CH_NORMAL, chip_state);
        idle(1, 1'b1);
        go(REF, 2'h0, 13'h0000, 1'b0);
        idle(2, 1'b0);
        chk("self", `CH_SELF, chip_state);
        idle(1, 1'b1);
        chk("sr exit", `CH_SREX, chip_state);
        for (i = 0; i < 12 && chip_state !== `CH_NORMAL; i = i + 1) idle(1, 1'b1);
        chk("sr done", `CH_NORMAL, chip_state);
        complete_run;
    end
endmodule // test_sdram_command_state_logic
bind sdram_command_state_logic sdram_command_state_logic_properties props_inst (.clk(clk), .resetn(resetn),
    .clk_gate(clk_gate), .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .write_en_n(write_en_n), .bank_select(bank_select), .addr(addr), .bank_state(bank_state), .chip_state(chip_state),
    .row_addr(row_addr), .column_addr(column_addr), .auto_precharge_bit(auto_precharge_bit), .illegal_cmd(illegal_cmd));
